// *** sfohp_regs.vh ***
// Purpose: constants for the serial flash pin front end
// Assumes: included by bare name
// Notes: no software-visible registers exist
`ifndef SFOHP_REGS_VH
`define SFOHP_REGS_VH
`define SFOHP_CMD_WIDTH 8
`define SFOHP_CMD_READ_SINGLE 8'h03
`define SFOHP_CMD_READ_DUAL 8'h3B
`define SFOHP_DUMMY_BITS 8
`define SFOHP_BUF_DEPTH 2
`endif

// *** sfohp_buf2.v ***
// Purpose: two-entry valid/ready buffer for outgoing data words
// Assumes: one clock, asynchronous active-low reset
// Notes: full and empty are exact; no word is lost on a stall
`timescale 1ns/1ns
module sfohp_buf2 #(
    parameter WIDTH = 8
) (
    // clock and reset
    input wire i_clk_sys,
    input wire i_rst_n,
    // fill side
    input wire i_in_valid,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_in_ready,
    // drain side
    output wire o_out_valid,
    output wire [WIDTH-1:0] o_out_data,
    input wire i_out_ready
);
    reg [WIDTH-1:0] mem_q [0:1];
    reg wr_ptr_q;
    reg rd_ptr_q;
    reg [1:0] count_q;
    wire push;
    wire pop;

    assign o_in_ready = (count_q != 2'h2);
    assign o_out_valid = (count_q != 2'h0);
    assign o_out_data = mem_q[rd_ptr_q];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mem_q[0] <= {WIDTH{1'b0}};
            mem_q[1] <= {WIDTH{1'b0}};
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            if (push) begin
                mem_q[wr_ptr_q] <= i_in_data;
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            if (push && !pop) begin
                count_q <= count_q + 2'h1;
            end else if (pop && !push) begin
                count_q <= count_q - 2'h1;
            end
        end
    end
endmodule

// *** sfohp_top.v ***
// Purpose: pin front end of a serial flash: shift in, shift out, dual read, hold, protect
// Assumes: host link pins are asynchronous and are oversampled by i_clk_sys
// Notes: read data is fetched from the memory side through a two-entry buffer
`timescale 1ns/1ns
`include "sfohp_regs.vh"
module sfohp_top #(
    parameter CMD_W = `SFOHP_CMD_WIDTH,
    parameter DUMMY = `SFOHP_DUMMY_BITS
) (
    // clock and reset
    input wire i_clk_sys,
    input wire i_rst_n,
    // host link pins
    input wire i_cs_n,
    input wire i_sck,
    input wire i_si,
    input wire i_wp_n,
    input wire i_hold_n,
    output reg o_dual_data_line_0,
    output reg o_dual_data_line_0_oe,
    output reg o_dual_data_line_1,
    output reg o_dual_data_line_1_oe,
    // command side: bytes captured from the host
    output reg o_rx_valid,
    output reg [CMD_W-1:0] o_rx_byte,
    output reg o_rx_first,
    // read data from the memory side
    input wire i_rd_valid,
    input wire [CMD_W-1:0] i_rd_data,
    output reg o_rd_ready,
    // protection and busy
    input wire i_busy,
    output reg o_wp_lock,
    output reg o_held,
    output reg o_standby
);
    // synchronisers: three stages, change taken when stage 2 and 3 agree
    reg [2:0] cs_s_q;
    reg [2:0] sck_s_q;
    reg [2:0] si_s_q;
    reg [2:0] wp_s_q;
    reg [2:0] hold_s_q;
    reg cs_q;
    reg sck_q;
    reg si_q;
    reg wp_q;
    reg hold_q;

    function filt;
        input [2:0] s;
        input cur;
        begin
            filt = (s[1] == s[2]) ? s[2] : cur;
        end
    endfunction

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cs_s_q <= 3'h7;
            sck_s_q <= 3'h0;
            si_s_q <= 3'h0;
            wp_s_q <= 3'h7;
            hold_s_q <= 3'h7;
            cs_q <= 1'b1;
            sck_q <= 1'b0;
            si_q <= 1'b0;
            wp_q <= 1'b1;
            hold_q <= 1'b1;
        end else begin
            cs_s_q <= {cs_s_q[1:0], i_cs_n};
            sck_s_q <= {sck_s_q[1:0], i_sck};
            si_s_q <= {si_s_q[1:0], i_si};
            wp_s_q <= {wp_s_q[1:0], i_wp_n};
            hold_s_q <= {hold_s_q[1:0], i_hold_n};
            cs_q <= filt(cs_s_q, cs_q);
            sck_q <= filt(sck_s_q, sck_q);
            si_q <= filt(si_s_q, si_q);
            wp_q <= filt(wp_s_q, wp_q);
            hold_q <= filt(hold_s_q, hold_q);
        end
    end

    wire sck_now = filt(sck_s_q, sck_q);
    wire cs_now = filt(cs_s_q, cs_q);
    wire selected = !cs_q;

    // hold state: starts only when selected and clock low, ends on pause release
    reg held_q;
    reg held_d;
    wire hold_start = selected && !hold_q && !sck_q && !held_q;
    wire hold_end = held_q && hold_q;

    // deselect wins so a frame cut mid-hold never leaves the part paused
    always @* begin
        held_d = held_q;
        if (cs_q) begin
            held_d = 1'b0;
        end else if (hold_start) begin
            held_d = 1'b1;
        end else if (hold_end) begin
            held_d = 1'b0;
        end
    end

    // edges are masked while held so clock activity is ignored
    wire sck_rise = selected && !held_q && !sck_q && sck_now;
    wire sck_fall = selected && !held_q && sck_q && !sck_now;
    wire frame_start = cs_q && !cs_now;
    wire frame_end = !cs_q && cs_now;

    localparam ST_CMD = 2'h0;
    localparam ST_DUMMY = 2'h1;
    localparam ST_READ = 2'h2;
    localparam ST_OTHER = 2'h3;

    reg [1:0] state_q;
    reg dual_q;
    reg [CMD_W-1:0] sh_in_q;
    reg [3:0] bit_cnt_q;
    reg first_q;
    reg [CMD_W-1:0] sh_out_q;
    reg [3:0] out_cnt_q;
    reg out_act_q;

    wire buf_valid;
    wire [CMD_W-1:0] buf_data;
    wire buf_in_ready;
    wire load_out = sck_fall && (state_q == ST_READ) && (out_cnt_q == 4'h0);
    wire buf_pop = load_out && buf_valid;

    // read starts once a word waits in the buffer; the source may already be idle
    wire read_go = (state_q == ST_DUMMY) && buf_valid;

    // ready leaves a flip-flop, so it is built from the next fill level;
    // a delayed copy of the buffer's ready would take one word too many
    function full_next;
        input not_full;
        input not_empty;
        input push;
        input pop;
        begin
            case ({not_full, not_empty})
                2'b01: begin
                    full_next = !pop;
                end
                2'b11: begin
                    full_next = push && !pop;
                end
                default: begin
                    full_next = 1'b0;
                end
            endcase
        end
    endfunction

    // words are offered to the buffer only while ready is shown to the source
    wire rd_push = i_rd_valid && o_rd_ready;

    sfohp_buf2 #(
        .WIDTH(CMD_W)
    ) u_buf (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_in_valid(rd_push),
        .i_in_data(i_rd_data),
        .o_in_ready(buf_in_ready),
        .o_out_valid(buf_valid),
        .o_out_data(buf_data),
        .i_out_ready(buf_pop)
    );

    // counter is four bits wide, so the byte length is cut on purpose
    wire [31:0] byte_bits_w = CMD_W;
    wire [3:0] byte_bits = byte_bits_w[3:0];
    wire [CMD_W-1:0] sh_in_next = {sh_in_q[CMD_W-2:0], si_q};

    // input shifter and command decode; state kept across a hold
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_CMD;
            dual_q <= 1'b0;
            sh_in_q <= {CMD_W{1'b0}};
            bit_cnt_q <= 4'h0;
            first_q <= 1'b1;
            o_rx_valid <= 1'b0;
            o_rx_byte <= {CMD_W{1'b0}};
            o_rx_first <= 1'b0;
            held_q <= 1'b0;
        end else begin
            held_q <= held_d;
            o_rx_valid <= 1'b0;
            if (frame_start || frame_end) begin
                state_q <= ST_CMD;
                dual_q <= 1'b0;
                bit_cnt_q <= 4'h0;
                first_q <= 1'b1;
            end else if (sck_rise && (state_q != ST_READ)) begin
                sh_in_q <= sh_in_next;
                if (bit_cnt_q == byte_bits - 4'h1) begin
                    bit_cnt_q <= 4'h0;
                    o_rx_valid <= 1'b1;
                    o_rx_byte <= sh_in_next;
                    o_rx_first <= first_q;
                    first_q <= 1'b0;
                    case (state_q)
                        ST_CMD: begin
                            if (sh_in_next == `SFOHP_CMD_READ_DUAL) begin
                                dual_q <= 1'b1;
                                state_q <= ST_DUMMY;
                            end else if (sh_in_next == `SFOHP_CMD_READ_SINGLE) begin
                                state_q <= ST_DUMMY;
                            end else begin
                                state_q <= ST_OTHER;
                            end
                        end
                        ST_DUMMY: begin
                            // memory side counts address bytes; read starts as soon as a word waits in the buffer, not after a dummy byte
                            if (sh_in_next == {CMD_W{1'b0}} || DUMMY == 0) begin
                                state_q <= ST_DUMMY;
                            end
                        end
                        default: begin
                            state_q <= state_q;
                        end
                    endcase
                end else begin
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                end
            end
            if (!frame_start && !frame_end && read_go) begin
                state_q <= ST_READ;
            end
        end
    end

    // output shifter: changes only on falling serial clock
    wire [3:0] step = dual_q ? 4'h2 : 4'h1;
    wire [CMD_W-1:0] src = (out_cnt_q == 4'h0) ? buf_data : sh_out_q;
    wire [3:0] cnt_load = byte_bits - step;

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sh_out_q <= {CMD_W{1'b0}};
            out_cnt_q <= 4'h0;
            out_act_q <= 1'b0;
            o_dual_data_line_0 <= 1'b0;
            o_dual_data_line_1 <= 1'b0;
            o_dual_data_line_0_oe <= 1'b0;
            o_dual_data_line_1_oe <= 1'b0;
            o_rd_ready <= 1'b0;
            o_wp_lock <= 1'b0;
            o_held <= 1'b0;
            o_standby <= 1'b1;
        end else begin
            // matches the buffer's own ready every cycle after the first
            o_rd_ready <= !full_next(buf_in_ready, buf_valid, rd_push, buf_pop);
            o_wp_lock <= !wp_q;
            o_held <= held_d;
            // standby waits for a self-timed cycle; busy is not gated by hold
            o_standby <= cs_q && !i_busy;
            if (frame_start || frame_end) begin
                out_cnt_q <= 4'h0;
                out_act_q <= 1'b0;
            end else if (sck_fall && state_q == ST_READ) begin
                out_act_q <= 1'b1;
                if (out_cnt_q == 4'h0 && !buf_valid) begin
                    // underrun: repeat idle bits rather than stall the host clock
                    o_dual_data_line_1 <= 1'b0;
                    o_dual_data_line_0 <= 1'b0;
                end else begin
                    if (dual_q) begin
                        o_dual_data_line_1 <= src[CMD_W-1];
                        o_dual_data_line_0 <= src[CMD_W-2];
                    end else begin
                        o_dual_data_line_1 <= src[CMD_W-1];
                    end
                    sh_out_q <= dual_q ? {src[CMD_W-3:0], 2'b00} : {src[CMD_W-2:0], 1'b0};
                    out_cnt_q <= (out_cnt_q == 4'h0) ? cnt_load : out_cnt_q - step;
                end
            end
            // floats when deselected or held
            o_dual_data_line_1_oe <= !cs_now && !held_d && out_act_q;
            o_dual_data_line_0_oe <= !cs_now && !held_d && out_act_q && dual_q;
        end
    end
endmodule

// *** sfohp_asserts.sv ***
// Purpose: concurrent checks on the serial flash pin front end
// Assumes: serial clock half period spans many system clocks
// Notes: repeat counts cover the pin synchronisers
`timescale 1ns/1ns
module sfohp_asserts (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // watched ports
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_wp_n,
    input wire logic i_hold_n,
    input wire logic i_busy,
    input wire logic o_dual_data_line_0_oe,
    input wire logic o_dual_data_line_1,
    input wire logic o_dual_data_line_1_oe,
    input wire logic o_rx_valid,
    input wire logic o_wp_lock,
    input wire logic o_held,
    input wire logic o_standby
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    AST_OUT_ON_FALL: assert property (
        o_dual_data_line_1_oe && $past(o_dual_data_line_1_oe) && $changed(o_dual_data_line_1)
        |-> !$past(i_sck) && !$past(i_sck, 2)) else $error("output moved off a clock fall");
    AST_FLOAT_DESEL: assert property (
        i_cs_n [*8] |-> !o_dual_data_line_1_oe && !o_dual_data_line_0_oe)
        else $error("line driven while deselected");
    AST_LOCK_LOW: assert property (
        !i_wp_n [*8] |-> o_wp_lock) else $error("low protect not locking");
    AST_LOCK_HIGH: assert property (
        i_wp_n [*8] |-> !o_wp_lock) else $error("high protect still locking");
    AST_HOLD_FLOAT: assert property (
        o_held [*2] |-> !o_dual_data_line_1_oe && !o_dual_data_line_0_oe)
        else $error("line driven during hold");
    AST_HOLD_SEL_ONLY: assert property (
        i_cs_n [*8] |-> !o_held) else $error("hold while deselected");
    AST_PAUSE_HIGH: assert property (
        i_hold_n [*8] |-> !o_held) else $error("hold with pause high");
    AST_NO_STANDBY: assert property (
        (i_busy || !i_cs_n) [*8] |-> !o_standby) else $error("standby while busy or selected");
    AST_STANDBY: assert property (
        (i_cs_n && !i_busy) [*8] |-> o_standby) else $error("no standby when idle");
    AST_RX_SPACING: assert property (
        o_rx_valid |=> !o_rx_valid [*8]) else $error("byte pulses too close");
    AST_DUAL_PAIR: assert property (
        o_dual_data_line_0_oe [*2] |-> o_dual_data_line_1_oe) else $error("line 0 alone");
endmodule
bind sfohp_top sfohp_asserts chk_u (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_cs_n(i_cs_n), .i_sck(i_sck), .i_wp_n(i_wp_n), .i_hold_n(i_hold_n),
    .i_busy(i_busy), .o_dual_data_line_0_oe(o_dual_data_line_0_oe),
    .o_dual_data_line_1(o_dual_data_line_1), .o_dual_data_line_1_oe(o_dual_data_line_1_oe),
    .o_rx_valid(o_rx_valid), .o_wp_lock(o_wp_lock), .o_held(o_held),
    .o_standby(o_standby));

// *** sfohp_host.sv ***
// Purpose: spi host model, mode 0, 160 ns serial clock
// Assumes: device output settles within half a serial clock
// Notes: line 0 is released during dual transfers
`timescale 1ns/1ns
module sfohp_host (
    // link pins
    output logic o_cs_n,
    output logic o_sck,
    output logic o_si,
    output logic o_si_oe,
    output logic o_hold_n,
    // device data lines
    input wire logic i_dl0,
    input wire logic i_dl1
);
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
        o_si_oe = 1'b1;
        o_hold_n = 1'b1;
    end
    task automatic frame(input logic sel);
        #80 o_cs_n = !sel;
        #80;
    endtask
    // only called with clock low; callers choose the select state
    task automatic pause(input logic on);
        o_hold_n = !on;
        #160;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic dual, output logic [7:0] rx);
        o_si_oe = !dual;
        for (int i = 7; i >= 0; i = i - (dual ? 2 : 1)) begin
            o_si = tx[i];
            #80 o_sck = 1'b1;
            rx = dual ? {rx[5:0], i_dl1, i_dl0} : {rx[6:0], i_dl1};
            #80 o_sck = 1'b0;
        end
    endtask
endmodule

// *** sfohp_top_tb.sv ***
// Purpose: self-checking bench for the serial flash pin front end
// Assumes: host model drives the link, bench plays the memory side
// Notes: a released line 0 toggles so a stale level is never trusted
`timescale 1ns/1ns
module sfohp_top_tb;
    logic clk;
    logic rst_n;
    logic wp_n;
    logic busy;
    logic rd_valid;
    logic [7:0] rd_data;
    logic tog;
    logic cs_n, sck, si, si_oe, hold_n, si_w, so_w, hs;
    logic dl0, dl0_oe, dl1, dl1_oe, rx_valid, rx_first, rd_ready, wp_lock, held, standby;
    logic [7:0] rx_byte, rx;
    logic [7:0] mem_q[$];
    logic [8:0] rx_q[$];
    int err_total = 0;
    int num_checks = 0;
    assign si_w = dl0_oe ? dl0 : (si_oe ? si : tog);
    assign so_w = dl1_oe ? dl1 : tog;
    initial begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end
    sfohp_host host_u (.o_cs_n(cs_n), .o_sck(sck), .o_si(si), .o_si_oe(si_oe),
        .o_hold_n(hold_n), .i_dl0(si_w), .i_dl1(so_w));
    sfohp_top dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_sck(sck),
        .i_si(si_w), .i_wp_n(wp_n), .i_hold_n(hold_n), .o_dual_data_line_0(dl0),
        .o_dual_data_line_0_oe(dl0_oe), .o_dual_data_line_1(dl1),
        .o_dual_data_line_1_oe(dl1_oe), .o_rx_valid(rx_valid), .o_rx_byte(rx_byte),
        .o_rx_first(rx_first), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
        .o_rd_ready(rd_ready), .i_busy(busy), .o_wp_lock(wp_lock), .o_held(held),
        .o_standby(standby));
    // memory side: word held until taken at an edge with ready high
    always @(posedge clk) begin
        hs = rd_valid && rd_ready;
        if (rx_valid === 1'b1)
            rx_q.push_back({rx_first, rx_byte});
        #1;
        tog = !tog;
        if (hs)
            void'(mem_q.pop_front());
        rd_valid = mem_q.size() > 0;
        rd_data = rd_valid ? mem_q[0] : 8'h00;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic t_single;
        mem_q = '{8'hA5, 8'h3C, 8'hF0};
        host_u.frame(1'b1);
        host_u.xfer(8'h03, 1'b0, rx);
        check(rd_ready, 1'b0);
        host_u.xfer(8'h00, 1'b0, rx);
        check(rx, 8'hA5);
        host_u.pause(1'b1);
        check({held, dl1_oe}, 2'b10);
        host_u.xfer(8'h00, 1'b1, rx);
        host_u.pause(1'b0);
        for (int i = 0; i < 3; i++) begin
            host_u.xfer(8'h00, 1'b0, rx);
            check(rx, i == 0 ? 8'h3C : i == 1 ? 8'hF0 : 8'h00);
        end
        check(rd_ready, 1'b1);
        host_u.frame(1'b0);
        check({dl1_oe, rx_q.pop_front()}, {1'b0, 9'h103});
        $display("single read done");
    endtask
    task automatic t_dual;
        mem_q = '{8'h96, 8'h5A};
        host_u.frame(1'b1);
        host_u.xfer(8'h3B, 1'b0, rx);
        host_u.xfer(8'h00, 1'b1, rx);
        check({rx, dl0_oe, dl1_oe}, {8'h96, 2'b11});
        host_u.xfer(8'h00, 1'b1, rx);
        check(rx, 8'h5A);
        host_u.frame(1'b0);
        check({dl0_oe, dl1_oe}, 2'b00);
        $display("dual read done");
    endtask
    task automatic t_side;
        wp_n = 1'b0;
        cyc(8);
        check(wp_lock, 1'b1);
        wp_n = 1'b1;
        host_u.pause(1'b1);
        check({wp_lock, held}, 2'b00);
        host_u.pause(1'b0);
        busy = 1'b1;
        cyc(8);
        check(standby, 1'b0);
        rx_q.delete();
        host_u.frame(1'b1);
        host_u.xfer(8'h9F, 1'b0, rx);
        host_u.pause(1'b1);
        check({held, standby}, 2'b10);
        host_u.pause(1'b0);
        host_u.xfer(8'h11, 1'b0, rx);
        host_u.frame(1'b0);
        check(standby, 1'b0);
        busy = 1'b0;
        cyc(8);
        check({standby, rx_q[0], rx_q[1]}, {1'b1, 9'h19F, 9'h011});
        $display("protect and hold done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        wp_n = 1'b1;
        busy = 1'b0;
        rd_valid = 1'b0;
        rd_data = 8'h00;
        tog = 1'b0;
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        cyc(4);
        t_single();
        t_dual();
        t_side();
        end_of_test();
    end
    // about seven times the expected run
    initial begin
        #100000;
        err_total++;
        end_of_test();
    end
endmodule
